/* File: verilog/vlan_table_defs.svh */
`ifndef VLAN_TABLE_DEFS_SVH
`define VLAN_TABLE_DEFS_SVH

// Register indices; byte address is four times the index
`define VT_IDX_CMD 14'h180B
`define VT_IDX_WR_DATA 14'h180C
`define VT_IDX_RD_DATA 14'h180E

// Command register fields
`define VT_CMD_RNW_BIT 5
`define VT_CMD_SEL_BIT 4
`define VT_CMD_IDX_MSB 3
`define VT_CMD_WIDTH 6

// Entry layout
`define VT_ENTRY_WIDTH 18
`define VT_VID_WIDTH 12
`define VT_PRIO_WIDTH 3
`define VT_VLAN_ENTRIES 16
`define VT_PORTS 3

// Reset values
`define VT_VLAN_RESET 18'h0_0000
`define VT_PORT_RESET 18'h0_0001
`define VT_NULL_VID 12'h000

`endif

/* File: verilog/vlan_table_pkg.sv */
package vlan_table_pkg;
  `include "vlan_table_defs.svh"

  typedef struct packed {
    logic member2;
    logic untag2;
    logic member1;
    logic untag1;
    logic member0;
    logic untag0;
    logic [11:0] vid;
  } vlan_entry_type;

  typedef struct packed {
    logic [2:0] bcast_prio;
    logic [2:0] dflt_prio;
    logic [11:0] dflt_vid;
  } port_entry_type;

  typedef struct packed {
    logic rnw;
    logic port_sel;
    logic [3:0] index;
  } table_cmd_type;

  typedef struct packed {
    logic valid;
    logic [1:0] port;
    logic [11:0] vid;
    logic [2:0] prio;
  } frame_type;
endpackage

/* File: verilog/vid_member_lookup.sv */
`timescale 1ns/1ps
module vid_member_lookup
  import vlan_table_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire vlan_entry_type vlan_tab [16],
  input wire frame_type frame_in,
  input wire logic [2:0] admit_non_member,
  input wire logic [2:0] hybrid_egress,
  output frame_type frame_out,
  output logic matched,
  output logic [2:0] admit,
  output logic [2:0] untag
);
  logic [15:0] hit;
  logic [2:0] member_sel;
  logic [2:0] untag_sel;
  frame_type frame_ff, nxt_frame_ff;
  logic matched_ff, nxt_matched_ff;
  logic [2:0] admit_ff, nxt_admit_ff;
  logic [2:0] untag_ff, nxt_untag_ff;

  // Zero identifier marks a disabled entry and never matches
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_hit
      assign hit[g] = (vlan_tab[g].vid != `VT_NULL_VID) && (vlan_tab[g].vid == frame_in.vid);
    end
  endgenerate

  always_comb
  begin
    member_sel = 3'h0;
    untag_sel = 3'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (hit[i])
      begin
        member_sel = {vlan_tab[i].member2, vlan_tab[i].member1, vlan_tab[i].member0};
        untag_sel = {vlan_tab[i].untag2, vlan_tab[i].untag1, vlan_tab[i].untag0};
      end
    end
    nxt_frame_ff = frame_in;
    nxt_matched_ff = frame_in.valid && (hit != 16'h0000);
    nxt_admit_ff = frame_in.valid ? (member_sel | admit_non_member) : 3'h0;
    nxt_untag_ff = frame_in.valid ? (untag_sel & hybrid_egress) : 3'h0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_ff <= '0;
      matched_ff <= 1'b0;
      admit_ff <= 3'h0;
      untag_ff <= 3'h0;
    end
    else
    begin
      frame_ff <= nxt_frame_ff;
      matched_ff <= nxt_matched_ff;
      admit_ff <= nxt_admit_ff;
      untag_ff <= nxt_untag_ff;
    end
  end

  assign frame_out = frame_ff;
  assign matched = matched_ff;
  assign admit = admit_ff;
  assign untag = untag_ff;
endmodule

/* File: verilog/vlan_table_access.sv */
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module vlan_table_access
  import vlan_table_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [15:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic FRM_VALID,
  input wire logic [1:0] FRM_PORT,
  input wire logic FRM_TAGGED,
  input wire logic [11:0] FRM_VID,
  input wire logic [2:0] FRM_PRIO,
  input wire logic FRM_PRIO_CHOSEN,
  input wire logic FRM_BCAST,
  input wire logic VLAN_DISABLE,
  input wire logic [2:0] ADMIT_NON_MEMBER_CTRL,
  input wire logic [2:0] EGRESS_PORT_TYPE_CTRL,
  output logic RES_VALID,
  output logic [1:0] RES_PORT,
  output logic [11:0] RES_VID,
  output logic [2:0] RES_PRIO,
  output logic RES_MATCH,
  output logic [2:0] RES_ADMIT,
  output logic [2:0] RES_UNTAG
);
  // Bus slave state
  logic ack_ff, nxt_ack_ff;
  logic [31:0] dat_o_ff, nxt_dat_o_ff;
  table_cmd_type cmd_ff, nxt_cmd_ff;
  logic [17:0] wr_data_ff, nxt_wr_data_ff;
  logic go_ff, nxt_go_ff;
  logic [17:0] rd_data_ff, nxt_rd_data_ff;

  // Tables
  vlan_entry_type vlan_tab_ff [16];
  vlan_entry_type nxt_vlan_tab_ff [16];
  port_entry_type port_tab_ff [3];
  port_entry_type nxt_port_tab_ff [3];

  // Frame stage
  frame_type frame_ff, nxt_frame_ff;
  frame_type frame_res;

  logic bus_req;
  logic bus_wr;
  logic [13:0] word_idx;
  logic [31:0] cmd_word;
  logic [31:0] lane_mask;
  port_entry_type frm_entry;

  assign bus_req = CYC_I && STB_I && !ack_ff;
  assign bus_wr = bus_req && WE_I;
  assign word_idx = ADR_I[15:2];
  assign cmd_word = {26'h000_0000, cmd_ff};
  assign lane_mask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

  // Wishbone register access; answer one cycle after the request
  always_comb
  begin
    nxt_ack_ff = bus_req;
    nxt_dat_o_ff = dat_o_ff;
    nxt_cmd_ff = cmd_ff;
    nxt_wr_data_ff = wr_data_ff;
    nxt_go_ff = 1'b0;
    if (bus_req && !WE_I)
    begin
      unique case (word_idx)
        `VT_IDX_CMD: nxt_dat_o_ff = cmd_word;
        `VT_IDX_WR_DATA: nxt_dat_o_ff = {14'h0000, wr_data_ff};
        `VT_IDX_RD_DATA: nxt_dat_o_ff = {14'h0000, rd_data_ff};
        default: nxt_dat_o_ff = 32'h0000_0000;
      endcase
    end
    else if (bus_wr)
    begin
      nxt_dat_o_ff = 32'h0000_0000;
      unique case (word_idx)
        `VT_IDX_CMD:
        begin
          if (SEL_I[0])
          begin
            nxt_cmd_ff = DAT_I[`VT_CMD_WIDTH-1:0];
            nxt_go_ff = 1'b1;
          end
        end
        `VT_IDX_WR_DATA:
        begin
          nxt_wr_data_ff = (wr_data_ff & ~lane_mask[17:0]) | (DAT_I[17:0] & lane_mask[17:0]);
        end
        default: nxt_dat_o_ff = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_ff <= 1'b0;
      dat_o_ff <= 32'h0000_0000;
      cmd_ff <= '0;
      wr_data_ff <= 18'h0_0000;
      go_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= nxt_ack_ff;
      dat_o_ff <= nxt_dat_o_ff;
      cmd_ff <= nxt_cmd_ff;
      wr_data_ff <= nxt_wr_data_ff;
      go_ff <= nxt_go_ff;
    end
  end

  // Table command execution, one cycle after the command write
  always_comb
  begin
    nxt_vlan_tab_ff = vlan_tab_ff;
    nxt_port_tab_ff = port_tab_ff;
    nxt_rd_data_ff = rd_data_ff;
    if (go_ff)
    begin
      if (cmd_ff.port_sel)
      begin
        if (cmd_ff.index < 4'h3)
        begin
          if (cmd_ff.rnw)
            nxt_rd_data_ff = port_tab_ff[cmd_ff.index[1:0]];
          else
            nxt_port_tab_ff[cmd_ff.index[1:0]] = wr_data_ff;
        end
        else if (cmd_ff.rnw)
        begin
          nxt_rd_data_ff = 18'h0_0000;
        end
      end
      else
      begin
        if (cmd_ff.rnw)
          nxt_rd_data_ff = vlan_tab_ff[cmd_ff.index];
        else
          nxt_vlan_tab_ff[cmd_ff.index] = wr_data_ff;
      end
    end
  end

  genvar gv;
  generate
    for (gv = 0; gv < 16; gv = gv + 1)
    begin : g_vlan
      always_ff @(posedge MCLK or negedge RST_N)
      begin
        if (!RST_N)
          vlan_tab_ff[gv] <= `VT_VLAN_RESET;
        else
          vlan_tab_ff[gv] <= nxt_vlan_tab_ff[gv];
      end
    end
    for (gv = 0; gv < 3; gv = gv + 1)
    begin : g_port
      always_ff @(posedge MCLK or negedge RST_N)
      begin
        if (!RST_N)
          port_tab_ff[gv] <= `VT_PORT_RESET;
        else
          port_tab_ff[gv] <= nxt_port_tab_ff[gv];
      end
    end
  endgenerate

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      rd_data_ff <= 18'h0_0000;
    else
      rd_data_ff <= nxt_rd_data_ff;
  end

  // Per-frame default identifier and priority
  always_comb
  begin
    frm_entry = (FRM_PORT < 2'h3) ? port_tab_ff[FRM_PORT] : '0;
    nxt_frame_ff.valid = FRM_VALID;
    nxt_frame_ff.port = FRM_PORT;
    if (VLAN_DISABLE || !FRM_TAGGED || FRM_VID == `VT_NULL_VID)
      nxt_frame_ff.vid = frm_entry.dflt_vid;
    else
      nxt_frame_ff.vid = FRM_VID;
    // Only a tagged, non-null frame can carry another chosen priority
    if (FRM_PRIO_CHOSEN && FRM_TAGGED && FRM_VID != `VT_NULL_VID)
      nxt_frame_ff.prio = FRM_PRIO;
    else if (FRM_BCAST)
      nxt_frame_ff.prio = frm_entry.bcast_prio;
    else
      nxt_frame_ff.prio = frm_entry.dflt_prio;
    if (!FRM_VALID)
      nxt_frame_ff = '0;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      frame_ff <= '0;
    else
      frame_ff <= nxt_frame_ff;
  end

  vid_member_lookup u_lookup (
    .clk(MCLK),
    .rst_n(RST_N),
    .vlan_tab(vlan_tab_ff),
    .frame_in(frame_ff),
    .admit_non_member(ADMIT_NON_MEMBER_CTRL),
    .hybrid_egress(EGRESS_PORT_TYPE_CTRL),
    .frame_out(frame_res),
    .matched(RES_MATCH),
    .admit(RES_ADMIT),
    .untag(RES_UNTAG)
  );

  assign ACK_O = ack_ff;
  assign DAT_O = dat_o_ff;
  assign RES_VALID = frame_res.valid;
  assign RES_PORT = frame_res.port;
  assign RES_VID = frame_res.vid;
  assign RES_PRIO = frame_res.prio;
endmodule

/* File: dv/vlan_table_access_monitor.sv */
`timescale 1ns/1ps
module vlan_table_access_monitor (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic FRM_VALID,
  input wire logic FRM_TAGGED,
  input wire logic [11:0] FRM_VID,
  input wire logic [2:0] FRM_PRIO,
  input wire logic FRM_PRIO_CHOSEN,
  input wire logic VLAN_DISABLE,
  input wire logic [2:0] ADMIT_NON_MEMBER_CTRL,
  input wire logic [2:0] EGRESS_PORT_TYPE_CTRL,
  input wire logic RES_VALID,
  input wire logic [11:0] RES_VID,
  input wire logic [2:0] RES_PRIO,
  input wire logic [2:0] RES_ADMIT,
  input wire logic [2:0] RES_UNTAG
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_ack;
    ACK_O ##1 !ACK_O;
  endsequence
  sequence s_tagged;
    FRM_VALID && FRM_TAGGED && FRM_VID != 12'h000 && !VLAN_DISABLE;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_ack) else $error("ack late");
  a_wr_data_zero: assert property (ACK_O && WE_I |-> DAT_O == 32'h0000_0000)
    else $error("write data");
  a_rd_reserved: assert property (ACK_O |-> DAT_O[31:18] == 14'h0000)
    else $error("reserved bits");
  a_res_delay: assert property (FRM_VALID |-> ##2 RES_VALID) else $error("no result");
  a_tag_vid: assert property (s_tagged |-> ##2 RES_VID == $past(FRM_VID, 2))
    else $error("tag vid");
  a_prio_chosen: assert property (s_tagged ##0 FRM_PRIO_CHOSEN |-> ##2
    RES_PRIO == $past(FRM_PRIO, 2)) else $error("chosen prio");
  a_admit_non_member: assert property (RES_VALID |->
    (RES_ADMIT | ~$past(ADMIT_NON_MEMBER_CTRL, 2)) == 3'h7) else $error("admit");
  a_untag_hybrid: assert property (RES_VALID |->
    (RES_UNTAG & ~$past(EGRESS_PORT_TYPE_CTRL, 2)) == 3'h0) else $error("untag");
endmodule
bind vlan_table_access vlan_table_access_monitor i_mon (.*);

/* File: dv/tb_vlan_table_access.sv */
`timescale 1ns/1ps
module tb_vlan_table_access;
  import vlan_table_pkg::*;
  localparam logic [15:0] A_CMD = 16'h602C;
  localparam logic [15:0] A_WD = 16'h6030;
  localparam logic [15:0] A_RD = 16'h6038;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] dat = 32'h0000_0000;
  logic fv = 1'b0;
  logic [1:0] fp = 2'h0;
  logic ft = 1'b0;
  logic [11:0] fid = 12'h000;
  logic [2:0] fpr = 3'h0;
  logic fch = 1'b0;
  logic fbc = 1'b0;
  logic dis = 1'b0;
  logic [2:0] anm = 3'h0;
  logic [2:0] ept = 3'h0;
  logic [31:0] dout;
  logic ack, rv, rm;
  logic [1:0] rp;
  logic [11:0] rid;
  logic [2:0] rpr, rad, run;
  vlan_entry_type vt [16];
  port_entry_type pt [3];
  logic [31:0] bus_q [$];
  logic [16:0] res_q [$];
  logic [6:0] m_q [$];
  logic [31:0] r;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 6;
  always #2 mclk = ~mclk;
  vlan_table_access i_dut (.MCLK(mclk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dout), .ACK_O(ack), .FRM_VALID(fv),
    .FRM_PORT(fp), .FRM_TAGGED(ft), .FRM_VID(fid), .FRM_PRIO(fpr), .FRM_PRIO_CHOSEN(fch),
    .FRM_BCAST(fbc), .VLAN_DISABLE(dis), .ADMIT_NON_MEMBER_CTRL(anm),
    .EGRESS_PORT_TYPE_CTRL(ept), .RES_VALID(rv), .RES_PORT(rp), .RES_VID(rid),
    .RES_PRIO(rpr), .RES_MATCH(rm), .RES_ADMIT(rad), .RES_UNTAG(run));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    if (ack === 1'b1)
      chk(dout, bus_q.pop_front());
    if (rv === 1'b1)
      chk({15'h0000, rp, rid, rpr}, res_q.pop_front());
    if (rv === 1'b1)
      chk({25'h000_0000, rm, rad, run}, m_q.pop_front());
  end
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    int n;
    bus_q.push_back(e);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    {cyc, stb, we} <= 3'h0;
    @(posedge mclk);
    if (n >= 50)
    begin
      error_cnt++;
      results();
    end
  endtask
  task automatic tw(input logic [5:0] c, input logic [17:0] d);
    wb(1'b1, A_WD, {14'h0000, d}, Z);
    wb(1'b1, A_CMD, {26'h000_0000, c}, Z);
  endtask
  task automatic tr(input logic [5:0] c, input logic [17:0] e);
    wb(1'b1, A_CMD, {26'h000_0000, c}, Z);
    wb(1'b0, A_RD, Z, {14'h0000, e});
  endtask
  // Leaves the frame valid high so frames run back to back
  task automatic frm(input logic [1:0] p, input logic t, input logic [11:0] v,
                     input logic [2:0] pr, input logic ch, input logic bc, input logic d);
    logic dv;
    logic [11:0] ev;
    logic [6:0] m;
    dv = !t || v == 12'h000 || d;
    ev = dv ? pt[p].dflt_vid : v;
    m = 7'h00;
    // Lowest matching enabled entry decides membership and untag
    for (int i = 15; i >= 0; i--)
      if (ev != 12'h000 && vt[i].vid == ev)
        m = {1'b1, vt[i].member2, vt[i].member1, vt[i].member0,
             vt[i].untag2, vt[i].untag1, vt[i].untag0};
    m_q.push_back({m[6], m[5:3] | anm, m[2:0] & ept});
    res_q.push_back({p, (dv ? pt[p].dflt_vid : v),
      ((!dv && ch) ? pr : (bc ? pt[p].bcast_prio : pt[p].dflt_prio))});
    {fv, fp, ft, fid, fpr, fch, fbc, dis} <= {1'b1, p, t, v, pr, ch, bc, d};
    @(posedge mclk);
  endtask
  initial
  begin
    anm <= 3'($random(seed));
    ept <= 3'($random(seed));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    wb(1'b0, A_RD, Z, Z);
    for (int p = 0; p < 3; p++)
    begin
      pt[p] = 18'h0_0001;
      tr({2'b11, 4'(p)}, pt[p]);
    end
    for (int i = 0; i < 16; i++)
    begin
      vt[i] = 18'($random(seed));
      vt[i].vid[11] = 1'b1;
      tw({2'b00, 4'(i)}, vt[i]);
    end
    for (int i = 0; i < 16; i++)
      tr({2'b10, 4'(i)}, vt[i]);
    for (int p = 0; p < 3; p++)
    begin
      pt[p] = 18'($random(seed));
      pt[p].dflt_vid[11] = 1'b0;
      pt[p].dflt_vid[0] = 1'b1;
      tw({2'b01, 4'(p)}, pt[p]);
      tr({2'b11, 4'(p)}, pt[p]);
    end
    tr(6'h33, 18'h0_0000);
    tr(6'h25, vt[5]);
    tw(6'h06, vt[6]);
    wb(1'b1, A_RD, 32'hFFFF_FFFF, Z);
    wb(1'b0, A_RD, Z, {14'h0000, vt[5]});
    wb(1'b0, 16'h0100, Z, Z);
    repeat (60)
    begin
      r = $random(seed);
      frm(2'(r[31:16] % 3), r[0], (r[1] ? vt[r[11:8]].vid : 12'h000), r[4:2],
          r[5] & !r[6], r[7] & !r[0], r[6]);
    end
    fv <= 1'b0;
    repeat (4) @(posedge mclk);
    results();
  end
endmodule
